// [hdl/bpcd_bridge_policy.sv]
`timescale 1ns/1ps
module bpcd_bridge_policy (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // Register port
   input  wire logic [7:0]              regAddr,
   input  wire logic [31:0]             regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic [31:0]                  regRdata,
   // Bus mode pins, asynchronous
   input  wire logic                    pinPciXMode,
   input  wire logic                    pinBus64,
   input  wire logic                    pinFastBus,
   // Link request (memory TLP from upstream)
   input  wire logic                    linkReqValid,
   input  wire logic [31:0]             linkReqAddr,
   output logic                         linkFwdDown,
   output logic                         linkUnsupported,
   // Conventional bus request
   input  wire bpcd_pkg::bpcd_req_t     busReq,
   input  wire logic                    busIsCompletion,
   input  wire logic                    bufSpaceOk,
   input  wire logic                    busReqDone,
   output logic                         busFwdUp,
   output logic                         busIgnore,
   output logic                         busRetry,
   output logic                         busCacheHit,
   output logic [12:0]                  fetchBytes,
   // Completion buffer reservation
   input  wire logic                    cplSpaceOk,
   output logic                         readIssue,
   // Credits
   output bpcd_pkg::bpcd_credits_t      credits,
   output logic [12:0]                  pdCreditBytes
);
   // Synchronised mode pins
   logic [2:0] modeMeta_q;
   logic [2:0] mode_q;
   logic       pciXMode;
   logic       bus64;
   logic       fastBus;

   // Registers
   bpcd_pkg::bpcd_pfctl_t pfCtl_q, pfCtl_d;
   logic        stcEn_q, stcEn_d;
   logic        memEn_q, memEn_d;
   logic        bmEn_q, bmEn_d;
   logic [7:0]  cacheLineDw_q, cacheLineDw_d;
   logic [11:0] memBase_q, memBase_d, memLimit_q, memLimit_d;
   logic [11:0] pfBase_q, pfBase_d, pfLimit_q, pfLimit_d;
   logic [15:0] stcPeriod_q, stcPeriod_d;
   logic [31:0] regRdata_q, regRdata_d;

   // Short-term cache
   logic        cacheValid_q, cacheValid_d;
   logic        cachePart_q, cachePart_d;
   logic [31:0] cacheAddr_q, cacheAddr_d;
   logic [12:0] cacheLeft_q, cacheLeft_d;
   logic [15:0] stcTimer_q, stcTimer_d;

   // Output registers
   logic        linkFwdDown_q, linkFwdDown_d;
   logic        linkUnsup_q, linkUnsup_d;
   logic        busFwdUp_q, busFwdUp_d;
   logic        busIgnore_q, busIgnore_d;
   logic        busCacheHit_q, busCacheHit_d;
   logic [12:0] fetchBytes_q, fetchBytes_d;

   logic        linkMemHit, busMemHit, busPfHit;
   logic [12:0] fetchCalc;
   logic        isRead;
   logic        stcExpire;

   bpcd_window_decode uLinkWin (
      .baseMb  (memBase_q),
      .limitMb (memLimit_q),
      .addr    (linkReqAddr),
      .hit     (linkMemHit)
   );

   bpcd_window_decode uBusWin (
      .baseMb  (memBase_q),
      .limitMb (memLimit_q),
      .addr    (busReq.addr),
      .hit     (busMemHit)
   );

   bpcd_window_decode uBusPfWin (
      .baseMb  (pfBase_q),
      .limitMb (pfLimit_q),
      .addr    (busReq.addr),
      .hit     (busPfHit)
   );

   bpcd_prefetch_size uSize (
      .pfCtl       (pfCtl_q),
      .pciXMode    (pciXMode),
      .bus64       (bus64),
      .fastBus     (fastBus),
      .cacheLineDw (cacheLineDw_q),
      .cmd         (busReq.cmd),
      .byteCount   (busReq.byteCount),
      .fetchBytes  (fetchCalc)
   );

   // Mode pins come from outside; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeMeta_q <= 3'h0;
         mode_q     <= 3'h0;
      end else begin
         modeMeta_q <= {pinPciXMode, pinBus64, pinFastBus};
         mode_q     <= modeMeta_q;
      end
   end
   assign pciXMode = mode_q[2];
   assign bus64    = mode_q[1];
   assign fastBus  = mode_q[0];

   // Credits are constants advertised at link start
   always_comb begin
      credits.ph   = bpcd_pkg::PH_CREDITS;
      credits.pd   = bpcd_pkg::PD_CREDITS;
      credits.nph  = bpcd_pkg::NPH_CREDITS;
      credits.npd  = bpcd_pkg::NPD_CREDITS;
      credits.cplh = bpcd_pkg::CPLH_CREDITS;
      credits.cpld = bpcd_pkg::CPLD_CREDITS;
      pdCreditBytes = 13'(bpcd_pkg::PD_CREDITS << bpcd_pkg::CREDIT_SHIFT);
   end

   // Register file
   always_comb begin
      pfCtl_d       = pfCtl_q;
      stcEn_d       = stcEn_q;
      memEn_d       = memEn_q;
      bmEn_d        = bmEn_q;
      cacheLineDw_d = cacheLineDw_q;
      memBase_d     = memBase_q;
      memLimit_d    = memLimit_q;
      pfBase_d      = pfBase_q;
      pfLimit_d     = pfLimit_q;
      stcPeriod_d   = stcPeriod_q;
      regRdata_d    = 32'h0000_0000;
      if (regWr) begin
         unique case (regAddr)
            bpcd_pkg::ADDR_PFCTL:  pfCtl_d = regWdata[14:0];
            bpcd_pkg::ADDR_MISC: begin
               stcEn_d       = regWdata[0];
               cacheLineDw_d = regWdata[15:8];
            end
            bpcd_pkg::ADDR_CMD: begin
               memEn_d = regWdata[1];
               bmEn_d  = regWdata[2];
            end
            bpcd_pkg::ADDR_MEMWIN: begin
               memBase_d  = regWdata[15:4];
               memLimit_d = regWdata[31:20];
            end
            bpcd_pkg::ADDR_PFWIN: begin
               pfBase_d  = regWdata[15:4];
               pfLimit_d = regWdata[31:20];
            end
            bpcd_pkg::ADDR_STCPER: stcPeriod_d = regWdata[15:0];
            default: ;
         endcase
      end
      if (regRd) begin
         unique case (regAddr)
            bpcd_pkg::ADDR_PFCTL:  regRdata_d = {17'h0_0000, pfCtl_q};
            bpcd_pkg::ADDR_MISC:   regRdata_d = {16'h0000, cacheLineDw_q, 7'h00, stcEn_q};
            bpcd_pkg::ADDR_CMD:    regRdata_d = {29'h0000_0000, bmEn_q, memEn_q, 1'b0};
            bpcd_pkg::ADDR_MEMWIN: regRdata_d = {memLimit_q, 4'h0, memBase_q, 4'h0};
            bpcd_pkg::ADDR_PFWIN:  regRdata_d = {pfLimit_q, 4'h0, pfBase_q, 4'h0};
            bpcd_pkg::ADDR_CREDIT: regRdata_d = {credits.nph[3:0], credits.npd[3:0],
                                                 credits.ph, credits.pd[7:0], 8'h00};
            bpcd_pkg::ADDR_STATUS: regRdata_d = {3'h0, cacheLeft_q, 7'h00, mode_q,
                                                 4'h0, cachePart_q, cacheValid_q};
            bpcd_pkg::ADDR_STCPER: regRdata_d = {16'h0000, stcPeriod_q};
            default:               regRdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pfCtl_q       <= bpcd_pkg::PFCTL_RESET[14:0];
         stcEn_q       <= 1'b0;
         memEn_q       <= 1'b0;
         bmEn_q        <= 1'b0;
         cacheLineDw_q <= 8'h00;
         memBase_q     <= 12'hFFF;
         memLimit_q    <= 12'h000;
         pfBase_q      <= 12'hFFF;
         pfLimit_q     <= 12'h000;
         stcPeriod_q   <= bpcd_pkg::STC_PERIOD;
         regRdata_q    <= 32'h0000_0000;
      end else begin
         pfCtl_q       <= pfCtl_d;
         stcEn_q       <= stcEn_d;
         memEn_q       <= memEn_d;
         bmEn_q        <= bmEn_d;
         cacheLineDw_q <= cacheLineDw_d;
         memBase_q     <= memBase_d;
         memLimit_q    <= memLimit_d;
         pfBase_q      <= pfBase_d;
         pfLimit_q     <= pfLimit_d;
         stcPeriod_q   <= stcPeriod_d;
         regRdata_q    <= regRdata_d;
      end
   end
   assign regRdata = regRdata_q;

   // Forwarding decode and short-term cache
   assign isRead    = busReq.valid && !busReq.posted && (busReq.cmd != bpcd_pkg::CMD_OTHER);
   assign stcExpire = cachePart_q && (stcTimer_q == 16'h0000);

   always_comb begin
      linkFwdDown_d = 1'b0;
      linkUnsup_d   = 1'b0;
      busFwdUp_d    = 1'b0;
      busIgnore_d   = 1'b0;
      busCacheHit_d = 1'b0;
      fetchBytes_d  = fetchBytes_q;
      cacheValid_d  = cacheValid_q;
      cachePart_d   = cachePart_q;
      cacheAddr_d   = cacheAddr_q;
      cacheLeft_d   = cacheLeft_q;
      stcTimer_d    = (cachePart_q && stcTimer_q != 16'h0000) ? stcTimer_q - 16'h0001
                                                               : stcTimer_q;
      if (linkReqValid) begin
         linkUnsup_d   = !memEn_q;
         linkFwdDown_d = memEn_q && linkMemHit;
      end
      if (busReq.valid && !busIsCompletion) begin
         if (!bmEn_q) begin
            busIgnore_d = 1'b1;
         end else begin
            // Memory disabled leaves no window claimed, so all goes up
            busFwdUp_d = !memEn_q || (!busMemHit && !busPfHit);
         end
      end
      if (isRead && bmEn_q && busFwdUp_d) begin
         if (cacheValid_q && busReq.addr == cacheAddr_q) begin
            busCacheHit_d = 1'b1;
            cachePart_d   = 1'b0;
         end else begin
            fetchBytes_d = fetchCalc;
         end
      end
      if (busReqDone) begin
         // Cache only pays off when the master streams back soon
         if (stcEn_q && !pciXMode) begin
            cacheValid_d = 1'b1;
            cachePart_d  = 1'b1;
            cacheAddr_d  = busReq.addr + 32'(busReq.byteCount);
            cacheLeft_d  = fetchBytes_q - busReq.byteCount;
            stcTimer_d   = stcPeriod_q;
         end else begin
            cacheValid_d = 1'b0;
            cachePart_d  = 1'b0;
         end
      end
      if (stcExpire || (busReq.valid && busReq.posted)) begin
         cacheValid_d = 1'b0;
         cachePart_d  = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         linkFwdDown_q <= 1'b0;
         linkUnsup_q   <= 1'b0;
         busFwdUp_q    <= 1'b0;
         busIgnore_q   <= 1'b0;
         busCacheHit_q <= 1'b0;
         fetchBytes_q  <= 13'h0000;
         cacheValid_q  <= 1'b0;
         cachePart_q   <= 1'b0;
         cacheAddr_q   <= 32'h0000_0000;
         cacheLeft_q   <= 13'h0000;
         stcTimer_q    <= 16'h0000;
      end else begin
         linkFwdDown_q <= linkFwdDown_d;
         linkUnsup_q   <= linkUnsup_d;
         busFwdUp_q    <= busFwdUp_d;
         busIgnore_q   <= busIgnore_d;
         busCacheHit_q <= busCacheHit_d;
         fetchBytes_q  <= fetchBytes_d;
         cacheValid_q  <= cacheValid_d;
         cachePart_q   <= cachePart_d;
         cacheAddr_q   <= cacheAddr_d;
         cacheLeft_q   <= cacheLeft_d;
         stcTimer_q    <= stcTimer_d;
      end
   end

   assign linkFwdDown     = linkFwdDown_q;
   assign linkUnsupported = linkUnsup_q;
   assign busFwdUp        = busFwdUp_q;
   assign busIgnore       = busIgnore_q;
   assign busCacheHit     = busCacheHit_q;
   assign fetchBytes      = fetchBytes_q;
   // Completions never retried; requests only on lack of space
   assign busRetry  = busReq.valid && !busIsCompletion && bmEn_q && !bufSpaceOk;
   // Space for returned data is reserved before the read goes out
   assign readIssue = busFwdUp_q && !busCacheHit_q && cplSpaceOk;

   sequence S_LINK_NOMEM;
      linkReqValid && !memEn_q;
   endsequence

   AST_UR_NO_MEM: assert property (@(posedge clk) disable iff (!rst_n)
      S_LINK_NOMEM |=> linkUnsupported && !linkFwdDown)
      else $error("Link memory request not UR with memory disabled");
   AST_NO_BM_IGNORE: assert property (@(posedge clk) disable iff (!rst_n)
      (busReq.valid && !busIsCompletion && !bmEn_q) |=> busIgnore && !busFwdUp)
      else $error("Bus transaction not ignored without master enable");
   AST_CPL_NO_RETRY: assert property (@(posedge clk) disable iff (!rst_n)
      busIsCompletion |-> !busRetry)
      else $error("Completion delivery retried");
   AST_RETRY_SPACE: assert property (@(posedge clk) disable iff (!rst_n)
      busRetry |-> !bufSpaceOk)
      else $error("Retry issued while buffer space free");
   AST_WIN_FWD: assert property (@(posedge clk) disable iff (!rst_n)
      linkFwdDown |-> $past(memBase_q <= memLimit_q) && $past(linkReqValid))
      else $error("Forwarded down with disabled window");
   AST_POST_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      (busReq.valid && busReq.posted) |=> !cacheValid_q)
      else $error("Cache kept after upstream posted write");
   AST_PCIX_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
      pciXMode |-> fetchCalc == busReq.byteCount)
      else $error("PCI-X fetch differs from byte count");
   AST_EXPIRE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      stcExpire |=> !cacheValid_q && !cachePart_q)
      else $error("Cache survived discard timer");
   AST_NOCACHE_DROP: assert property (@(posedge clk) disable iff (!rst_n)
      (busReqDone && !stcEn_q) |=> !cacheValid_q)
      else $error("Leftover data kept with caching off");
   AST_CREDITS: assert property (@(posedge clk) disable iff (!rst_n)
      credits.ph == bpcd_pkg::PH_CREDITS && pdCreditBytes == 13'h0200)
      else $error("Posted credits wrong");
endmodule

// [hdl/bpcd_pkg.sv]
package bpcd_pkg;
   localparam logic [7:0]  PH_CREDITS   = 8'h08;
   localparam logic [11:0] PD_CREDITS   = 12'h020;
   localparam logic [7:0]  NPH_CREDITS  = 8'h04;
   localparam logic [11:0] NPD_CREDITS  = 12'h001;
   localparam logic [7:0]  CPLH_CREDITS = 8'h00;
   localparam logic [11:0] CPLD_CREDITS = 12'h000;
   localparam int          CREDIT_BYTES = 16;
   localparam int          CREDIT_SHIFT = 4;
   localparam int          WIN_SHIFT    = 20;
   localparam logic [12:0] DW_BYTES     = 13'h0004;
   localparam logic [12:0] LINE_DEF32   = 13'h0080;
   localparam logic [12:0] LINE_DEF64   = 13'h0100;
   localparam logic [12:0] MULT_DEF32   = 13'h0100;
   localparam logic [12:0] MULT_DEF64   = 13'h0180;
   localparam int          LEN_SHIFT    = 5;
   localparam logic [15:0] STC_PERIOD   = 16'h0100;
   localparam logic [7:0]  ADDR_PFCTL   = 8'h00;
   localparam logic [7:0]  ADDR_MISC    = 8'h04;
   localparam logic [7:0]  ADDR_CMD     = 8'h08;
   localparam logic [7:0]  ADDR_MEMWIN  = 8'h0C;
   localparam logic [7:0]  ADDR_PFWIN   = 8'h10;
   localparam logic [7:0]  ADDR_CREDIT  = 8'h14;
   localparam logic [7:0]  ADDR_STATUS  = 8'h18;
   localparam logic [7:0]  ADDR_STCPER  = 8'h1C;
   localparam logic [31:0] PFCTL_RESET  = 32'h0000_0036;

   typedef enum logic [1:0] {CMD_MR, CMD_MRL, CMD_MRM, CMD_OTHER} bpcd_cmd_t;

   // Last member sits in bit 0, so the select bits match the reset value
   typedef struct packed {
      logic [2:0]  multLenSlow;
      logic [2:0]  multLenFast;
      logic [2:0]  lineLenSlow;
      logic [2:0]  lineLenFast;
      logic        multSel;
      logic        lineSel;
      logic        memReadSel;
   } bpcd_pfctl_t;

   typedef struct packed {
      logic [7:0]  ph;
      logic [11:0] pd;
      logic [7:0]  nph;
      logic [11:0] npd;
      logic [7:0]  cplh;
      logic [11:0] cpld;
   } bpcd_credits_t;

   typedef struct packed {
      logic        valid;
      bpcd_cmd_t   cmd;
      logic [31:0] addr;
      logic [12:0] byteCount;
      logic        posted;
   } bpcd_req_t;
endpackage

// [hdl/bpcd_prefetch_size.sv]
`timescale 1ns/1ps
module bpcd_prefetch_size (
   // Configuration
   input  wire bpcd_pkg::bpcd_pfctl_t pfCtl,
   input  wire logic                  pciXMode,
   input  wire logic                  bus64,
   input  wire logic                  fastBus,
   input  wire logic [7:0]            cacheLineDw,
   // Request
   input  wire bpcd_pkg::bpcd_cmd_t   cmd,
   input  wire logic [12:0]           byteCount,
   // Result
   output logic [12:0]                fetchBytes
);
   logic [12:0] lineBytes;
   logic [12:0] progLine;
   logic [12:0] progMult;
   always_comb begin
      lineBytes = {3'h0, cacheLineDw, 2'h0};
      progLine = {7'h00, (fastBus ? pfCtl.lineLenFast : pfCtl.lineLenSlow), 3'h0}
                 << bpcd_pkg::LEN_SHIFT;
      progMult = {7'h00, (fastBus ? pfCtl.multLenFast : pfCtl.multLenSlow), 3'h0}
                 << bpcd_pkg::LEN_SHIFT;
      if (pciXMode) begin
         fetchBytes = byteCount;
      end else begin
         unique case (cmd)
            bpcd_pkg::CMD_MR: begin
               // Plain reads stay minimal unless software opts in
               fetchBytes = !pfCtl.memReadSel ? (bus64 ? 13'(2*bpcd_pkg::DW_BYTES)
                                                 : bpcd_pkg::DW_BYTES) : progLine;
            end
            bpcd_pkg::CMD_MRL: begin
               if (!pfCtl.lineSel) fetchBytes = lineBytes;
               else fetchBytes = bus64 ? bpcd_pkg::LINE_DEF64 : bpcd_pkg::LINE_DEF32;
            end
            bpcd_pkg::CMD_MRM: begin
               if (!pfCtl.multSel) fetchBytes = 13'(lineBytes << 1);
               else fetchBytes = bus64 ? bpcd_pkg::MULT_DEF64 : bpcd_pkg::MULT_DEF32;
            end
            default: fetchBytes = byteCount;
         endcase
      end
   end
endmodule

// [hdl/bpcd_window_decode.sv]
`timescale 1ns/1ps
module bpcd_window_decode (
   // Window bounds in 1 MB units
   input  wire logic [11:0] baseMb,
   input  wire logic [11:0] limitMb,
   // Address under test
   input  wire logic [31:0] addr,
   // Result
   output logic             hit
);
   logic [11:0] addrMb;
   assign addrMb = addr[31:bpcd_pkg::WIN_SHIFT];
   assign hit = (baseMb <= limitMb) && (addrMb >= baseMb) && (addrMb <= limitMb);
endmodule

// [test/bpcd_link_partner.sv]
`timescale 1ns/1ps
module bpcd_link_partner (
   // Clock
   input  wire logic        clk,
   // Memory request toward the bridge
   output logic             linkReqValid,
   output logic [31:0]      linkReqAddr,
   // Bridge answer
   input  wire logic        linkFwdDown,
   input  wire logic        linkUnsupported
);
   initial begin
      linkReqValid = 1'b0;
      linkReqAddr  = 32'h0000_0000;
   end
   // Address is scrambled once released so a stale value never looks valid
   task automatic send(input logic [31:0] a, output logic fwd, output logic ur);
      @(posedge clk);
      linkReqValid <= 1'b1;
      linkReqAddr  <= a;
      @(posedge clk);
      linkReqValid <= 1'b0;
      linkReqAddr  <= ~a;
      #1;
      fwd = linkFwdDown;
      ur  = linkUnsupported;
   endtask
endmodule

// [test/test_bridge_prefetch_credit_decode.sv]
`timescale 1ns/1ps
module test_bridge_prefetch_credit_decode;
   logic                    clk, rst_n, regWr, regRd, busIsCompletion, bufSpaceOk;
   logic                    busReqDone, cplSpaceOk, pinPciXMode, pinBus64, pinFastBus;
   logic                    linkReqValid, linkFwdDown, linkUnsupported;
   logic                    busFwdUp, busIgnore, busRetry, busCacheHit, readIssue;
   logic                    up, ign, hit, iss, rt, fwd, ur;
   logic [7:0]              regAddr;
   logic [31:0]             regWdata, regRdata, linkReqAddr, rd;
   logic [12:0]             fetchBytes, pdCreditBytes, fb;
   bpcd_pkg::bpcd_req_t     busReq;
   bpcd_pkg::bpcd_credits_t credits;
   int                      errTotal, compares;

   bpcd_bridge_policy bpcd_bridge_policy_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .pinPciXMode(pinPciXMode), .pinBus64(pinBus64), .pinFastBus(pinFastBus),
      .linkReqValid(linkReqValid), .linkReqAddr(linkReqAddr), .linkFwdDown(linkFwdDown),
      .linkUnsupported(linkUnsupported), .busReq(busReq), .busIsCompletion(busIsCompletion),
      .bufSpaceOk(bufSpaceOk), .busReqDone(busReqDone), .busFwdUp(busFwdUp),
      .busIgnore(busIgnore), .busRetry(busRetry), .busCacheHit(busCacheHit),
      .fetchBytes(fetchBytes), .cplSpaceOk(cplSpaceOk), .readIssue(readIssue),
      .credits(credits), .pdCreditBytes(pdCreditBytes));
   bpcd_link_partner bpcd_link_partner_i (.clk(clk), .linkReqValid(linkReqValid),
      .linkReqAddr(linkReqAddr), .linkFwdDown(linkFwdDown), .linkUnsupported(linkUnsupported));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr    <= 1'b0;
   endtask

   task automatic regRead(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd   <= 1'b0;
      #1 rd = regRdata;
   endtask

   // Retry is sampled mid-cycle, registered answers just after the taking edge
   task automatic busOp(input bpcd_pkg::bpcd_cmd_t c, input logic [31:0] a,
                        input logic [12:0] bc);
      @(posedge clk);
      busReq <= '{valid: 1'b1, cmd: c, addr: a, byteCount: bc, posted: 1'b0};
      @(negedge clk);
      rt = busRetry;
      @(posedge clk);
      busReq <= '0;
      #1;
      {up, ign, hit, iss, fb} = {busFwdUp, busIgnore, busCacheHit, readIssue, fetchBytes};
   endtask

   // Done pulse carries the finished read's address; a posted pulse is a write
   task automatic busPulse(input logic p, input logic [31:0] a, input logic [12:0] bc);
      @(posedge clk);
      busReqDone <= !p;
      busReq     <= '{valid: p, cmd: (p ? bpcd_pkg::CMD_OTHER : bpcd_pkg::CMD_MRL),
                      addr: a, byteCount: bc, posted: p};
      @(posedge clk);
      busReqDone <= 1'b0;
      busReq     <= '0;
   endtask

   task automatic tCredits;
      check("hdrCredits", 32'h0000_0804, {credits.ph, credits.nph});
      check("dataCredits", 32'h0002_0001, {credits.pd, credits.npd});
      check("cplCredits", 32'h0000_0000, {credits.cplh, credits.cpld});
      check("pdBytes", 32'h0000_0200, pdCreditBytes);
      regRead(8'h40);
      check("unmapped", 32'h0000_0000, rd);
   endtask

   task automatic tLink;
      bpcd_link_partner_i.send(32'h0010_0000, fwd, ur);
      check("urMemOff", 32'h0000_0001, {fwd, ur});
      regWrite(8'h0C, 32'h0010_0020);
      regWrite(8'h08, 32'h0000_0002);
      bpcd_link_partner_i.send(32'h0010_0000, fwd, ur);
      check("baseAboveLimit", 32'h0000_0000, {fwd, ur});
      regWrite(8'h0C, 32'h0010_0010);
      bpcd_link_partner_i.send(32'h0010_0000, fwd, ur);
      check("winLow", 32'h0000_0002, {fwd, ur});
      bpcd_link_partner_i.send(32'h001F_FFFC, fwd, ur);
      check("winHigh", 32'h0000_0002, {fwd, ur});
      bpcd_link_partner_i.send(32'h0020_0000, fwd, ur);
      check("winAbove", 32'h0000_0000, {fwd, ur});
      bpcd_link_partner_i.send(32'h000F_FFFC, fwd, ur);
      check("winBelow", 32'h0000_0000, {fwd, ur});
   endtask

   task automatic tBusGate;
      busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0004);
      check("ignoreMaster", 32'h0000_0001, {up, ign});
      regWrite(8'h08, 32'h0000_0006);
      busOp(bpcd_pkg::CMD_MR, 32'h0010_0040, 13'h0004);
      check("insideNoUp", 32'h0000_0000, {up, ign});
      busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0004);
      check("outsideUp", 32'h0000_0005, {up, ign, iss});
      @(posedge clk) cplSpaceOk <= 1'b0;
      busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0004);
      check("noSpaceNoIssue", 32'h0000_0004, {up, ign, iss});
      @(posedge clk) cplSpaceOk <= 1'b1;
   endtask

   task automatic tPrefetch;
      logic [12:0] e [2][3] = '{'{13'h0004, 13'h0080, 13'h0100},
                                '{13'h0008, 13'h0100, 13'h0180}};
      for (int w = 0; w < 2; w++) begin
         @(posedge clk) pinBus64 <= w[0];
         repeat (4) @(posedge clk);
         busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0040);
         check("fetchMr", e[w][0], fb);
         busOp(bpcd_pkg::CMD_MRL, 32'h0400_0000, 13'h0040);
         check("fetchMrl", e[w][1], fb);
         busOp(bpcd_pkg::CMD_MRM, 32'h0400_0000, 13'h0040);
         check("fetchMrm", e[w][2], fb);
      end
      @(posedge clk) pinPciXMode <= 1'b1;
      repeat (4) @(posedge clk);
      busOp(bpcd_pkg::CMD_MRM, 32'h0400_0000, 13'h0044);
      check("pcixExact", 32'h0000_0044, fb);
      @(posedge clk) {pinPciXMode, pinBus64} <= 2'b00;
      repeat (4) @(posedge clk);
   endtask

   // Cacheline of 8 doublewords makes one line 32 bytes
   task automatic tLineSel;
      regWrite(8'h04, 32'h0000_0800);
      regWrite(8'h00, 32'h0000_0030);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0000, 13'h0040);
      check("lineOne", 32'h0000_0020, fb);
      busOp(bpcd_pkg::CMD_MRM, 32'h0400_0000, 13'h0040);
      check("multTwo", 32'h0000_0040, fb);
      regRead(8'h00);
      check("pfctlBack", 32'h0000_0030, rd);
   endtask

   task automatic tRetryCache;
      @(posedge clk) bufSpaceOk <= 1'b0;
      busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0004);
      check("retryFull", 32'h0000_0001, rt);
      @(posedge clk) busIsCompletion <= 1'b1;
      busOp(bpcd_pkg::CMD_MR, 32'h0400_0000, 13'h0004);
      check("noRetryCpl", 32'h0000_0000, rt);
      @(posedge clk) {bufSpaceOk, busIsCompletion} <= 2'b10;
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0000, 13'h0040);
      busPulse(1'b0, 32'h0400_0000, 13'h0020);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0020, 13'h0040);
      check("discardNoCache", 32'h0000_0000, hit);
   endtask

   // Cacheline is 32 bytes, so a 16-byte read leaves 16 bytes cached
   task automatic tCache;
      regWrite(8'h04, 32'h0000_0801);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0000, 13'h0010);
      busPulse(1'b0, 32'h0400_0000, 13'h0010);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0010, 13'h0010);
      check("stcHit", 32'h0000_0006, {up, hit, iss});
      busPulse(1'b1, 32'h0400_0100, 13'h0004);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0010, 13'h0010);
      check("postDrop", 32'h0000_0000, hit);
      regWrite(8'h1C, 32'h0000_0004);
      busPulse(1'b0, 32'h0400_0000, 13'h0010);
      repeat (8) @(posedge clk);
      busOp(bpcd_pkg::CMD_MRL, 32'h0400_0010, 13'h0010);
      check("expireDrop", 32'h0000_0000, hit);
   endtask

   initial begin
      {rst_n, regWr, regRd, busIsCompletion, busReqDone} = '0;
      {pinPciXMode, pinBus64, pinFastBus, bufSpaceOk, cplSpaceOk} = 5'b00011;
      {regAddr, regWdata, busReq} = '0;
      errTotal = 0;
      compares = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      tCredits();
      tLink();
      tBusGate();
      tPrefetch();
      tLineSel();
      tRetryCache();
      tCache();
      report_and_stop();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      report_and_stop();
   end
endmodule
